// ---- rtl/cbb_pkg.sv ----
// Shared constants, opcodes and states of the branch and bit-operation core
package cbb_pkg;

  // Register byte addresses on the Wishbone slave
  localparam int ADR_W = 8;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_DEST = 8'h0C;
  localparam logic [7:0] ADDR_SRC = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;

  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 6;
  localparam int CMD_BIT_LSB = 8;
  localparam int BIT_W = 3;
  localparam int CMD_K_LSB = 16;
  localparam int K_W = 7;

  // Status word fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_TAKEN = 1;
  localparam int STAT_CYC_LSB = 4;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // Flag positions inside the flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_BRANCH_CARRY_CLEAR = 6'h01,
    OP_BRANCH_SAME_OR_HIGHER = 6'h02,
    OP_BRANCH_LOWER = 6'h03,
    OP_BRANCH_NEGATIVE = 6'h04,
    OP_BRANCH_NONNEGATIVE = 6'h05,
    OP_BRANCH_SIGNED_GE = 6'h06,
    OP_BRANCH_SIGNED_LT = 6'h07,
    OP_BRANCH_HALF_CARRY_SET = 6'h08,
    OP_BRANCH_HALF_CARRY_CLEAR = 6'h09,
    OP_BRANCH_TBIT_SET = 6'h0A,
    OP_BRANCH_TBIT_CLEAR = 6'h0B,
    OP_BRANCH_OVERFLOW_SET = 6'h0C,
    OP_BRANCH_OVERFLOW_CLEAR = 6'h0D,
    OP_BRANCH_IRQ_ENABLED = 6'h0E,
    OP_BRANCH_IRQ_DISABLED = 6'h0F,
    OP_LOGICAL_RIGHT_SHIFT = 6'h10,
    OP_ROTATE_LEFT_CARRY = 6'h11,
    OP_ROTATE_RIGHT_CARRY = 6'h12,
    OP_ARITH_RIGHT_SHIFT = 6'h13,
    OP_NIBBLE_SWAP = 6'h14,
    OP_TBIT_STORE = 6'h15,
    OP_TBIT_LOAD = 6'h16,
    OP_SET_CARRY_FLAG = 6'h17,
    OP_CLEAR_CARRY_FLAG = 6'h18,
    OP_SET_NEGATIVE_FLAG = 6'h19,
    OP_CLEAR_NEGATIVE_FLAG = 6'h1A,
    OP_SET_ZERO_FLAG = 6'h1B,
    OP_CLEAR_ZERO_FLAG = 6'h1C,
    OP_SET_IRQ_ENABLE = 6'h1D,
    OP_CLEAR_IRQ_ENABLE = 6'h1E,
    OP_SET_SIGN_TEST_FLAG = 6'h1F,
    OP_CLEAR_SIGN_TEST_FLAG = 6'h20,
    OP_SET_OVERFLOW_FLAG = 6'h21
  } cbb_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_JUMP = 3'h4
  } cbb_state_t;

endpackage : cbb_pkg

// ---- rtl/cbb_exec_if.sv ----
// Operand and result bundle between the core and its two evaluation units
`timescale 1ns/100ps
interface cbb_exec_if;
  import cbb_pkg::*;
  cbb_op_t op;
  logic [7:0] flags;
  logic [7:0] rd;
  logic [7:0] src;
  logic [BIT_W-1:0] bsel;
  logic br_valid;
  logic br_taken;
  logic [7:0] res;
  logic [7:0] res_flags;
  logic res_we;

  modport core (output op, flags, rd, src, bsel, input br_valid, br_taken, res, res_flags, res_we);
  modport branch (input op, flags, output br_valid, br_taken);
  modport bitop (input op, flags, rd, src, bsel, output res, res_flags, res_we);
endinterface : cbb_exec_if

// ---- rtl/cbb_branch_eval.sv ----
// Branch condition evaluation from the status flags
`timescale 1ns/100ps
module cbb_branch_eval
  import cbb_pkg::*;
(
  cbb_exec_if.branch ex
);

  always_comb
  begin
    ex.br_valid = 1'b1;
    ex.br_taken = 1'b0;
    unique case (ex.op)
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: ex.br_taken = ~ex.flags[FLAG_C];
      OP_BRANCH_LOWER: ex.br_taken = ex.flags[FLAG_C];
      OP_BRANCH_NEGATIVE: ex.br_taken = ex.flags[FLAG_N];
      OP_BRANCH_NONNEGATIVE: ex.br_taken = ~ex.flags[FLAG_N];
      OP_BRANCH_SIGNED_GE: ex.br_taken = ~(ex.flags[FLAG_N] ^ ex.flags[FLAG_V]);
      OP_BRANCH_SIGNED_LT: ex.br_taken = ex.flags[FLAG_N] ^ ex.flags[FLAG_V];
      OP_BRANCH_HALF_CARRY_SET: ex.br_taken = ex.flags[FLAG_H];
      OP_BRANCH_HALF_CARRY_CLEAR: ex.br_taken = ~ex.flags[FLAG_H];
      OP_BRANCH_TBIT_SET: ex.br_taken = ex.flags[FLAG_T];
      OP_BRANCH_TBIT_CLEAR: ex.br_taken = ~ex.flags[FLAG_T];
      OP_BRANCH_OVERFLOW_SET: ex.br_taken = ex.flags[FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR: ex.br_taken = ~ex.flags[FLAG_V];
      OP_BRANCH_IRQ_ENABLED: ex.br_taken = ex.flags[FLAG_I];
      OP_BRANCH_IRQ_DISABLED: ex.br_taken = ~ex.flags[FLAG_I];
      default: ex.br_valid = 1'b0;
    endcase
  end

endmodule : cbb_branch_eval

// ---- rtl/cbb_bit_unit.sv ----
// Shift, rotate, nibble swap, T-bit transfer and flag set/clear datapath
`timescale 1ns/100ps
module cbb_bit_unit
  import cbb_pkg::*;
(
  cbb_exec_if.bitop ex
);

  logic shift_op;
  logic carry_out;

  always_comb
  begin
    shift_op = 1'b0;
    carry_out = 1'b0;
    ex.res = ex.rd;
    ex.res_flags = ex.flags;
    ex.res_we = 1'b0;
    unique case (ex.op)
      OP_LOGICAL_RIGHT_SHIFT:
      begin
        ex.res = {1'b0, ex.rd[7:1]};
        carry_out = ex.rd[0];
        shift_op = 1'b1;
      end
      OP_ROTATE_LEFT_CARRY:
      begin
        ex.res = {ex.rd[6:0], ex.flags[FLAG_C]};
        carry_out = ex.rd[7];
        shift_op = 1'b1;
      end
      OP_ROTATE_RIGHT_CARRY:
      begin
        ex.res = {ex.flags[FLAG_C], ex.rd[7:1]};
        carry_out = ex.rd[0];
        shift_op = 1'b1;
      end
      OP_ARITH_RIGHT_SHIFT:
      begin
        ex.res = {ex.rd[7], ex.rd[7:1]};
        carry_out = ex.rd[0];
        shift_op = 1'b1;
      end
      OP_NIBBLE_SWAP:
      begin
        ex.res = {ex.rd[3:0], ex.rd[7:4]};
        ex.res_we = 1'b1;
      end
      OP_TBIT_STORE: ex.res_flags[FLAG_T] = ex.src[ex.bsel];
      OP_TBIT_LOAD:
      begin
        ex.res[ex.bsel] = ex.flags[FLAG_T];
        ex.res_we = 1'b1;
      end
      OP_SET_CARRY_FLAG: ex.res_flags[FLAG_C] = 1'b1;
      OP_CLEAR_CARRY_FLAG: ex.res_flags[FLAG_C] = 1'b0;
      OP_SET_NEGATIVE_FLAG: ex.res_flags[FLAG_N] = 1'b1;
      OP_CLEAR_NEGATIVE_FLAG: ex.res_flags[FLAG_N] = 1'b0;
      OP_SET_ZERO_FLAG: ex.res_flags[FLAG_Z] = 1'b1;
      OP_CLEAR_ZERO_FLAG: ex.res_flags[FLAG_Z] = 1'b0;
      OP_SET_IRQ_ENABLE: ex.res_flags[FLAG_I] = 1'b1;
      OP_CLEAR_IRQ_ENABLE: ex.res_flags[FLAG_I] = 1'b0;
      OP_SET_SIGN_TEST_FLAG: ex.res_flags[FLAG_S] = 1'b1;
      OP_CLEAR_SIGN_TEST_FLAG: ex.res_flags[FLAG_S] = 1'b0;
      OP_SET_OVERFLOW_FLAG: ex.res_flags[FLAG_V] = 1'b1;
      default: ex.res_we = 1'b0;
    endcase
    // Shifts and rotates share one flag update
    if (shift_op)
    begin
      ex.res_we = 1'b1;
      ex.res_flags[FLAG_C] = carry_out;
      ex.res_flags[FLAG_Z] = (ex.res == DATA_RST);
      ex.res_flags[FLAG_N] = ex.res[7];
      ex.res_flags[FLAG_V] = ex.res[7] ^ carry_out;
    end
  end

endmodule : cbb_bit_unit

// ---- rtl/cbb_exec_top.sv ----
// Conditional branch and bit-operation execution core with a Wishbone register slave
//
// Function
// - Carry clear or same-or-higher: branch when C=0
// - Minus branches on N=1, plus on N=0
// - Signed greater-or-equal branches when N xor V=0
// - Signed less-than branches when N xor V=1
// - Half-carry pair branches on H set/clear
// - T-bit pair branches on T set/clear
// - Overflow pair branches on V set/clear
// - Interrupt-enable pair branches on I set/clear
// - Logical right shift, zero into bit 7
// - Rotate left through carry, one cycle
// - Rotate right through carry, one cycle
// - Arithmetic right shift keeps the sign bit
// - Nibble swap, flags unchanged
// - Bit store copies selected bit into T
// - Bit load writes T into selected bit
// - Single flag set/clear for C, N, Z, S
// - Set overflow changes only V
`timescale 1ns/100ps
module cbb_exec_top
  import cbb_pkg::*;
#(
  parameter int PC_W = 16
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic busy_o,
  output logic [PC_W-1:0] pc_o,
  output logic [7:0] flags_o
);

  typedef struct packed {
    cbb_state_t st;
    logic busy;
    logic ack;
    logic [31:0] dat;
    logic [PC_W-1:0] pc;
    logic [7:0] flags;
    logic [7:0] rd;
    logic [7:0] src;
    cbb_op_t op;
    logic [K_W-1:0] koff;
    logic [BIT_W-1:0] bsel;
    logic taken;
    logic [1:0] cycles;
  } cbb_core_t;

  localparam cbb_core_t CORE_RST = '{
    st: ST_IDLE,
    busy: 1'b0,
    ack: 1'b0,
    dat: WORD_ZERO,
    pc: PC_W'(PC_RST),
    flags: FLAGS_RST,
    rd: DATA_RST,
    src: DATA_RST,
    op: OP_NOP,
    koff: K_W'(DATA_RST),
    bsel: BIT_W'(DATA_RST),
    taken: 1'b0,
    cycles: CYC_ONE
  };

  cbb_core_t s;
  cbb_core_t next_s;
  logic req;
  logic [31:0] wmerge;
  logic [31:0] rdata;

  cbb_exec_if ex ();

  //////////////////////////////////////////////////////////////////////////////
  // Evaluation units

  assign ex.op = s.op;
  assign ex.flags = s.flags;
  assign ex.rd = s.rd;
  assign ex.src = s.src;
  assign ex.bsel = s.bsel;

  cbb_branch_eval u_branch (
    .ex(ex)
  );

  cbb_bit_unit u_bits (
    .ex(ex)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wr,
                                              input logic [3:0] sel);
    logic [31:0] out;
    out = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        out[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return out;
  endfunction : merge_bytes

  function automatic logic [PC_W-1:0] sext_k(input logic [K_W-1:0] k);
    return {{(PC_W-K_W){k[K_W-1]}}, k};
  endfunction : sext_k

  //////////////////////////////////////////////////////////////////////////////
  // Register read view

  always_comb
  begin
    rdata = WORD_ZERO;
    unique case (wb_adr_i)
      ADDR_CMD:
      begin
        rdata[CMD_OP_LSB +: CMD_OP_W] = s.op;
        rdata[CMD_BIT_LSB +: BIT_W] = s.bsel;
        rdata[CMD_K_LSB +: K_W] = s.koff;
      end
      ADDR_FLAGS: rdata[7:0] = s.flags;
      ADDR_PC: rdata[PC_W-1:0] = s.pc;
      ADDR_DEST: rdata[7:0] = s.rd;
      ADDR_SRC: rdata[7:0] = s.src;
      ADDR_STAT:
      begin
        rdata[STAT_BUSY] = s.busy;
        rdata[STAT_TAKEN] = s.taken;
        rdata[STAT_CYC_LSB +: 2] = s.cycles;
      end
      default: rdata = WORD_ZERO;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_s = s;
    next_s.ack = 1'b0;
    // Requests wait while an instruction is in flight
    req = wb_cyc_i & wb_stb_i & ~s.ack & (s.st == ST_IDLE);
    wmerge = WORD_ZERO;
    unique case (s.st)
      ST_IDLE:
      begin
        if (req)
        begin
          next_s.ack = 1'b1;
          next_s.dat = rdata;
          if (wb_we_i)
          begin
            unique case (wb_adr_i)
              ADDR_CMD:
              begin
                wmerge = merge_bytes(rdata, wb_dat_i, wb_sel_i);
                next_s.op = cbb_op_t'(wmerge[CMD_OP_LSB +: CMD_OP_W]);
                next_s.bsel = wmerge[CMD_BIT_LSB +: BIT_W];
                next_s.koff = wmerge[CMD_K_LSB +: K_W];
                if (wb_sel_i[0])
                begin
                  next_s.st = ST_EXEC;
                end
              end
              ADDR_FLAGS:
              begin
                wmerge = merge_bytes(rdata, wb_dat_i, wb_sel_i);
                next_s.flags = wmerge[7:0];
              end
              ADDR_PC:
              begin
                wmerge = merge_bytes(rdata, wb_dat_i, wb_sel_i);
                next_s.pc = wmerge[PC_W-1:0];
              end
              ADDR_DEST:
              begin
                wmerge = merge_bytes(rdata, wb_dat_i, wb_sel_i);
                next_s.rd = wmerge[7:0];
              end
              ADDR_SRC:
              begin
                wmerge = merge_bytes(rdata, wb_dat_i, wb_sel_i);
                next_s.src = wmerge[7:0];
              end
              default: wmerge = WORD_ZERO;
            endcase
          end
        end
      end
      ST_EXEC:
      begin
        if (ex.br_valid && ex.br_taken)
        begin
          next_s.st = ST_JUMP;
          next_s.taken = 1'b1;
          next_s.cycles = CYC_TWO;
        end
        else
        begin
          next_s.st = ST_IDLE;
          next_s.pc = s.pc + PC_W'(1);
          next_s.flags = ex.res_flags;
          next_s.taken = 1'b0;
          next_s.cycles = CYC_ONE;
          if (ex.res_we)
          begin
            next_s.rd = ex.res;
          end
        end
      end
      ST_JUMP:
      begin
        // Second cycle of a taken branch, flags untouched
        next_s.pc = s.pc + sext_k(s.koff) + PC_W'(1);
        next_s.st = ST_IDLE;
      end
      default: next_s = CORE_RST;
    endcase
    next_s.busy = (next_s.st != ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s <= CORE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign busy_o = s.busy;
  assign pc_o = s.pc;
  assign flags_o = s.flags;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic in_exec;
  assign in_exec = (s.st == ST_EXEC);

  a_cc_branch_taken: assert property (
    (in_exec && (s.op inside {OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER}))
    |=> ((s.st == ST_JUMP) == !$past(s.flags[FLAG_C])))
    else $error("carry clear branch decision wrong");
  a_neg_branch_taken: assert property (
    (in_exec && s.op == OP_BRANCH_NEGATIVE) |=> ((s.st == ST_JUMP) == $past(s.flags[FLAG_N])))
    else $error("minus branch decision wrong");
  a_plus_branch_taken: assert property (
    (in_exec && s.op == OP_BRANCH_NONNEGATIVE) |=> ((s.st == ST_JUMP) == !$past(s.flags[FLAG_N])))
    else $error("plus branch decision wrong");
  a_ge_branch_taken: assert property (
    (in_exec && s.op == OP_BRANCH_SIGNED_GE)
    |=> ((s.st == ST_JUMP) == !($past(s.flags[FLAG_N]) ^ $past(s.flags[FLAG_V]))))
    else $error("signed ge branch decision wrong");
  a_lt_branch_taken: assert property (
    (in_exec && s.op == OP_BRANCH_SIGNED_LT)
    |=> ((s.st == ST_JUMP) == ($past(s.flags[FLAG_N]) ^ $past(s.flags[FLAG_V]))))
    else $error("signed lt branch decision wrong");
  a_half_branch_taken: assert property (
    (in_exec && s.op == OP_BRANCH_HALF_CARRY_CLEAR) |=> ((s.st == ST_JUMP) == !$past(s.flags[FLAG_H])))
    else $error("half carry branch decision wrong");
  a_tbit_branch_taken: assert property (
    (in_exec && s.op == OP_BRANCH_TBIT_SET) |=> ((s.st == ST_JUMP) == $past(s.flags[FLAG_T])))
    else $error("T flag branch decision wrong");
  a_ovf_branch_taken: assert property (
    (in_exec && s.op == OP_BRANCH_OVERFLOW_CLEAR) |=> ((s.st == ST_JUMP) == !$past(s.flags[FLAG_V])))
    else $error("overflow branch decision wrong");
  a_irq_branch_taken: assert property (
    (in_exec && s.op == OP_BRANCH_IRQ_DISABLED) |=> ((s.st == ST_JUMP) == !$past(s.flags[FLAG_I])))
    else $error("interrupt branch decision wrong");
  a_taken_two_cycles: assert property (
    (in_exec && ex.br_valid && ex.br_taken) |=> (s.st == ST_JUMP) ##1 (s.st == ST_IDLE && $stable(s.flags)))
    else $error("taken branch not two cycles");
  a_jump_target_pc: assert property (
    (s.st == ST_JUMP) |=> (s.pc == $past(s.pc) + sext_k($past(s.koff)) + PC_W'(1)))
    else $error("branch target wrong");
  a_not_taken_next: assert property (
    (in_exec && ex.br_valid && !ex.br_taken)
    |=> (s.st == ST_IDLE && s.pc == $past(s.pc) + PC_W'(1) && $stable(s.flags)))
    else $error("untaken branch not one cycle");
  a_lsr_result_flags: assert property (
    (in_exec && s.op == OP_LOGICAL_RIGHT_SHIFT)
    |=> (s.rd == {1'b0, $past(s.rd[7:1])} && s.flags[FLAG_C] == $past(s.rd[0]) && !s.flags[FLAG_N]))
    else $error("logical shift result wrong");
  a_rol_result_carry: assert property (
    (in_exec && s.op == OP_ROTATE_LEFT_CARRY)
    |=> (s.rd == {$past(s.rd[6:0]), $past(s.flags[FLAG_C])} && s.flags[FLAG_C] == $past(s.rd[7])))
    else $error("rotate left result wrong");
  a_ror_result_carry: assert property (
    (in_exec && s.op == OP_ROTATE_RIGHT_CARRY)
    |=> (s.rd == {$past(s.flags[FLAG_C]), $past(s.rd[7:1])} && s.flags[FLAG_C] == $past(s.rd[0])))
    else $error("rotate right result wrong");
  a_asr_sign_kept: assert property (
    (in_exec && s.op == OP_ARITH_RIGHT_SHIFT)
    |=> (s.rd == {$past(s.rd[7]), $past(s.rd[7:1])} && s.flags[FLAG_Z] == (s.rd == DATA_RST)))
    else $error("arithmetic shift result wrong");
  a_swap_nibbles: assert property (
    (in_exec && s.op == OP_NIBBLE_SWAP) |=> (s.rd == {$past(s.rd[3:0]), $past(s.rd[7:4])} && $stable(s.flags)))
    else $error("nibble swap wrong");
  a_tbit_store: assert property (
    (in_exec && s.op == OP_TBIT_STORE)
    |=> (s.flags[FLAG_T] == $past(s.src[s.bsel]) && s.flags[5:0] == $past(s.flags[5:0]) && $stable(s.rd)))
    else $error("bit store wrong");
  a_tbit_load: assert property (
    (in_exec && s.op == OP_TBIT_LOAD) |=> (s.rd[$past(s.bsel)] == s.flags[FLAG_T] && $stable(s.flags)))
    else $error("bit load wrong");
  a_clear_zero_only: assert property (
    (in_exec && s.op == OP_CLEAR_ZERO_FLAG) |=> (s.flags == ($past(s.flags) & ~(8'h01 << FLAG_Z))))
    else $error("zero flag clear wrong");
  a_set_ovf_only: assert property (
    (in_exec && s.op == OP_SET_OVERFLOW_FLAG) |=> (s.flags == ($past(s.flags) | (8'h01 << FLAG_V))))
    else $error("overflow set wrong");

endmodule : cbb_exec_top

// ---- verification/cbb_exec_top_tb.sv ----
// Self-checking testbench of the branch and bit-operation core
`timescale 1ns/100ps
module cbb_exec_top_tb;
  import cbb_pkg::*;
  logic clk_i;
  logic rst_n_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic busy_o;
  logic [15:0] pc_o;
  logic [7:0] flags_o;
  logic [31:0] rdat;
  logic [15:0] e_pc;
  logic [7:0] e_fl;
  logic [7:0] e_rd;
  logic e_tk;
  int fail_count;
  int check_count;
  integer seed;

  cbb_exec_top #(.PC_W(16)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .busy_o(busy_o), .pc_o(pc_o), .flags_o(flags_o));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Classic single cycle, held until ack is seen at a rising edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    // Idle slave answers one cycle after the taking edge
    chk(n, 32'h2, "ack latency");
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer

  ////////////////////////////////////////////////////////////////////////////////
  function automatic void model(input logic [5:0] op, input logic [7:0] fl, input logic [7:0] rd,
    input logic [7:0] src, input logic [2:0] b, input logic [6:0] k, input logic [15:0] pc);
    logic c;
    logic [7:0] r;
    logic cond;
    c = fl[FLAG_C];
    r = rd;
    cond = 1'b0;
    e_fl = fl;
    case (op)
      6'h01, 6'h02: cond = !fl[FLAG_C];
      6'h03: cond = fl[FLAG_C];
      6'h04: cond = fl[FLAG_N];
      6'h05: cond = !fl[FLAG_N];
      6'h06: cond = !(fl[FLAG_N] ^ fl[FLAG_V]);
      6'h07: cond = fl[FLAG_N] ^ fl[FLAG_V];
      6'h08: cond = fl[FLAG_H];
      6'h09: cond = !fl[FLAG_H];
      6'h0A: cond = fl[FLAG_T];
      6'h0B: cond = !fl[FLAG_T];
      6'h0C: cond = fl[FLAG_V];
      6'h0D: cond = !fl[FLAG_V];
      6'h0E: cond = fl[FLAG_I];
      6'h0F: cond = !fl[FLAG_I];
      6'h10: {r, c} = {1'b0, rd};
      6'h11: {c, r} = {rd, fl[FLAG_C]};
      6'h12: {r, c} = {fl[FLAG_C], rd};
      6'h13: {r, c} = {rd[7], rd};
      6'h14: r = {rd[3:0], rd[7:4]};
      6'h15: e_fl[FLAG_T] = src[b];
      6'h16: r[b] = fl[FLAG_T];
      6'h17: e_fl[FLAG_C] = 1'b1;
      6'h18: e_fl[FLAG_C] = 1'b0;
      6'h19: e_fl[FLAG_N] = 1'b1;
      6'h1A: e_fl[FLAG_N] = 1'b0;
      6'h1B: e_fl[FLAG_Z] = 1'b1;
      6'h1C: e_fl[FLAG_Z] = 1'b0;
      6'h1D: e_fl[FLAG_I] = 1'b1;
      6'h1E: e_fl[FLAG_I] = 1'b0;
      6'h1F: e_fl[FLAG_S] = 1'b1;
      6'h20: e_fl[FLAG_S] = 1'b0;
      6'h21: e_fl[FLAG_V] = 1'b1;
      default: cond = 1'b0;
    endcase
    if (op >= 6'h10 && op <= 6'h13)
    begin
      e_fl[FLAG_C] = c;
      e_fl[FLAG_Z] = (r == 8'h00);
      e_fl[FLAG_N] = r[7];
      e_fl[FLAG_V] = r[7] ^ c;
    end
    e_tk = cond;
    e_rd = r;
    e_pc = cond ? pc + {{9{k[6]}}, k} + 16'h0001 : pc + 16'h0001;
  endfunction : model

  task automatic run_op(input logic [5:0] op, input logic [7:0] fl, input logic [7:0] rd, input logic [7:0] src,
    input logic [2:0] b, input logic [6:0] k, input logic [15:0] pc);
    int n;
    wb_xfer(1'b1, ADDR_FLAGS, {24'h000000, fl}, 4'hF);
    wb_xfer(1'b1, ADDR_PC, {16'h0000, pc}, 4'hF);
    wb_xfer(1'b1, ADDR_DEST, {24'h000000, rd}, 4'hF);
    wb_xfer(1'b1, ADDR_SRC, {24'h000000, src}, 4'hF);
    model(op, fl, rd, src, b, k, pc);
    wb_xfer(1'b1, ADDR_CMD, {9'h000, k, 5'h00, b, 2'h0, op}, 4'hF);
    n = 1;
    @(negedge clk_i);
    while (busy_o === 1'b1 && n < 10)
    begin
      n++;
      @(negedge clk_i);
    end
    chk(n, e_tk ? 32'h2 : 32'h1, "cycles");
    chk({16'h0000, pc_o}, {16'h0000, e_pc}, "pc");
    chk({24'h000000, flags_o}, {24'h000000, e_fl}, "flags");
    wb_xfer(1'b0, ADDR_DEST, 32'h0, 4'hF);
    chk(rdat, {24'h000000, e_rd}, "dest");
    wb_xfer(1'b0, ADDR_STAT, 32'h0, 4'hF);
    chk(rdat & 32'h33, {26'h0, e_tk ? CYC_TWO : CYC_ONE, 2'h0, e_tk, 1'b0}, "stat");
  endtask : run_op

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    $display("ERROR %0t: watchdog expired", $time);
    summarize();
  end

  initial
  begin
    logic [7:0] fl;
    logic [7:0] rd;
    logic [6:0] k;
    logic [15:0] pc;
    fail_count = 0;
    check_count = 0;
    seed = 53928;
    rst_n_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk({15'h0, busy_o, pc_o}, 32'h0, "reset pc busy");
    chk({24'h000000, flags_o}, 32'h0, "reset flags");
    wb_xfer(1'b0, ADDR_STAT, 32'h0, 4'hF);
    chk(rdat, {26'h0, CYC_ONE, 4'h0}, "reset stat");
    wb_xfer(1'b1, 8'h18, 32'hFFFF_FFFF, 4'hF);
    wb_xfer(1'b0, 8'h18, 32'h0, 4'hF);
    chk(rdat, 32'h0, "unmapped read");
    wb_xfer(1'b0, ADDR_FLAGS, 32'h0, 4'hF);
    chk(rdat, 32'h0, "unmapped write");
    // Command with lane 0 disabled must not start
    wb_xfer(1'b1, ADDR_CMD, 32'h0000_0017, 4'hE);
    @(negedge clk_i);
    chk({15'h0, busy_o, pc_o}, 32'h0, "no start");
    for (int pass = 0; pass < 4; pass++)
    begin
      for (int op = 0; op <= 33; op++)
      begin
        fl = (pass == 2) ? 8'hFF : (pass == 3) ? 8'h00 : 8'($random(seed));
        rd = (pass == 0) ? 8'h80 : (pass == 1) ? 8'h01 : 8'($random(seed));
        k = (pass == 2) ? 7'h40 : (pass == 3) ? 7'h3F : 7'($random(seed));
        pc = (pass == 3) ? 16'hFFF0 : 16'($random(seed));
        run_op(6'(op), fl, rd, 8'($random(seed)), 3'($random(seed)), k, pc);
      end
    end
    for (int i = 0; i < 60; i++)
      run_op(6'($unsigned($random(seed)) % 34), 8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
        3'($random(seed)), 7'($random(seed)), 16'($random(seed)));
    summarize();
  end
endmodule : cbb_exec_top_tb
